// >>> sdc_ctrl.sv
// Purpose: Event, sleep and write-synchronization control of a converter
// Assumes: Event lines synchronous to mclk, gclk_tick marks generic clock
// Notes: Generic clock domain is modelled by a tick enable on mclk
// Overview of operation
// - Output events are emitted only while their output enable bit is set.
// - Input events can start a conversion or flush the one in progress.
// - An input event acts only while its input enable bit is one.
// - Input events act on the rising edge by default.
// - Invert enable flips the line before edge detection, giving falling edge.
// - Simultaneous flush and start perform the flush only.
// - Enable off disables; run in standby and on request shape sleep behaviour.
// - With on request set, analog powers down once a conversion completes.
// - On request start wakes the system, conversion follows analog start-up.
// - Synchronized accesses set their busy bit until synchronization ends.
// - A synchronized write while its busy bit is set errors, no effect.
// - Software reset and enable writes are synchronized and report busy.
// - Input, reference, control, window, correction, trigger, analog synced.
//
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
module sdc_ctrl
  import sdc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic gclk_tick,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire sdc_evline_s evt_in,
  input wire logic sleep_i,
  input wire logic standby_i,
  input wire logic [15:0] sample_i,
  output logic evt_resrdy_o,
  output logic evt_winmon_o,
  output logic wake_req_o,
  output logic analog_on_o,
  output logic converting_o
);
  // Address to sync target, SY_NONE where none
  function automatic logic [3:0] sync_idx(input logic [7:0] a);
    logic [7:0] off;
    off = a - ADR_SYNC0;
    if (a == ADR_MAIN)
      sync_idx = 4'(SY_ENABLE);
    else if (a >= ADR_SYNC0 && a < ADR_STATUS && a[1:0] == 2'b00)
      sync_idx = 4'(SY_INPUT) + 4'(off[7:2]);
    else
      sync_idx = 4'(SY_NONE);
  endfunction

  logic req_acc;
  logic [3:0] widx;
  logic [NSYNC-1:0] busy;
  logic [NSYNC-1:0] wr_go;
  logic [NSYNC-1:0] done;
  logic [15:0] cnv_val [NSYNC];
  logic soft_rst;
  logic [31:0] rd_mux;
  logic collide;
  logic lo_sel;

  // Bus slave
  logic ack_r, ack_nxt, err_r, err_nxt;
  logic [31:0] dat_r, dat_nxt;

  assign req_acc = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
  assign widx = sync_idx(wb_adr_i);
  assign lo_sel = wb_sel_i[0];
  // Main control write touches the enable target unless it collides, and software_reset_bit when that bit is set
  always_comb begin
    collide = 1'b0;
    wr_go = '0;
    if (req_acc && wb_we_i && lo_sel) begin
      if (wb_adr_i == ADR_MAIN) begin
        collide = (wb_dat_i[B_SOFTWARE_RESET_BIT] && busy[SY_SOFTWARE_RESET_BIT]) ||
                  busy[SY_ENABLE];
        if (!collide) begin
          wr_go[SY_SOFTWARE_RESET_BIT] = wb_dat_i[B_SOFTWARE_RESET_BIT];
          wr_go[SY_ENABLE] = 1'b1;
        end
      end else if (widx != 4'(SY_NONE)) begin
        collide = busy[widx];
        if (!collide)
          wr_go[widx] = 1'b1;
      end
    end
  end

  always_comb begin
    ack_nxt = req_acc && !collide;
    err_nxt = req_acc && collide;
    dat_nxt = wb_we_i ? 32'h0000_0000 : rd_mux;
    if (!req_acc)
      dat_nxt = dat_r;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else if (ce) begin
      ack_r <= ack_nxt;
      err_r <= err_nxt;
      dat_r <= dat_nxt;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;
  assign wb_dat_o = dat_r;

  // Write synchronization, one toggle handshake per target
  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : gsync
      logic req_r, req_nxt, cnv_r, cnv_nxt, ackt_r, ackt_nxt;
      logic [15:0] pend_r, pend_nxt, val_r, val_nxt;
      always_comb begin
        req_nxt = req_r;
        pend_nxt = pend_r;
        cnv_nxt = cnv_r;
        val_nxt = val_r;
        ackt_nxt = cnv_r;
        if (wr_go[g]) begin
          req_nxt = !req_r;
          if (g == SY_SOFTWARE_RESET_BIT || g == SY_ENABLE)
            pend_nxt = {15'h0000, wb_dat_i[g]};
          else
            pend_nxt = wb_dat_i[15:0];
        end
        if (gclk_tick && cnv_r != req_r) begin
          cnv_nxt = req_r;
          val_nxt = pend_r;
        end
        if (soft_rst && g != SY_SOFTWARE_RESET_BIT) begin
          req_nxt = 1'b0;
          cnv_nxt = 1'b0;
          ackt_nxt = 1'b0;
          val_nxt = SYNC_RST;
          pend_nxt = SYNC_RST;
        end
      end
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          req_r <= 1'b0;
          cnv_r <= 1'b0;
          ackt_r <= 1'b0;
          pend_r <= SYNC_RST;
          val_r <= SYNC_RST;
        end else if (ce) begin
          req_r <= req_nxt;
          cnv_r <= cnv_nxt;
          ackt_r <= ackt_nxt;
          pend_r <= pend_nxt;
          val_r <= val_nxt;
        end
      end
      // Busy holds from the write until the acknowledge returns
      assign busy[g] = req_r != ackt_r;
      assign done[g] = gclk_tick && cnv_r != req_r;
      assign cnv_val[g] = val_r;
    end
  endgenerate

  // Software reset lands when its request reaches the converter side
  assign soft_rst = done[SY_SOFTWARE_RESET_BIT] && gclk_tick &&
                    gsync[SY_SOFTWARE_RESET_BIT].pend_r[0];

  // Event control and sleep bits are not synchronized
  logic [5:0] evt_r, evt_nxt;
  logic runstby_r, runstby_nxt, onreq_r, onreq_nxt;
  sdc_evt_s ev;
  assign ev = sdc_evt_s'(evt_r);
  always_comb begin
    evt_nxt = evt_r;
    runstby_nxt = runstby_r;
    onreq_nxt = onreq_r;
    if (req_acc && wb_we_i && lo_sel && !collide) begin
      if (wb_adr_i == ADR_EVT)
        evt_nxt = wb_dat_i[5:0];
      if (wb_adr_i == ADR_MAIN) begin
        runstby_nxt = wb_dat_i[B_RUNSTBY];
        onreq_nxt = wb_dat_i[B_ONREQ];
      end
    end
    if (soft_rst) begin
      evt_nxt = EVT_RST;
      runstby_nxt = 1'b0;
      onreq_nxt = 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      evt_r <= EVT_RST;
      runstby_r <= 1'b0;
      onreq_r <= 1'b0;
    end else if (ce) begin
      evt_r <= evt_nxt;
      runstby_r <= runstby_nxt;
      onreq_r <= onreq_nxt;
    end
  end

  // Input event edges; channels are synchronous to mclk upstream
  sdc_evline_s ev_lvl, ev_prev_r;
  logic ev_start, ev_flush, sw_start, sw_flush, go_start, go_flush;
  assign ev_lvl.start = evt_in.start ^ ev.start_inv;
  assign ev_lvl.flush = evt_in.flush ^ ev.flush_inv;
  assign ev_start = ev_lvl.start && !ev_prev_r.start &&
                    ev.start_ei;
  assign ev_flush = ev_lvl.flush && !ev_prev_r.flush &&
                    ev.flush_ei;
  // Software trigger acts as its write lands on the converter side
  assign sw_start = done[SY_TRIG] && gsync[SY_TRIG].pend_r[B_TRIG_START];
  assign sw_flush = done[SY_TRIG] && gsync[SY_TRIG].pend_r[B_TRIG_FLUSH];
  assign go_flush = ev_flush || sw_flush;
  assign go_start = (ev_start || sw_start) && !go_flush;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      ev_prev_r <= '0;
    else if (ce)
      ev_prev_r <= ev_lvl;
  end

  // Conversion sequencer
  logic enabled, running;
  sdc_state_e st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic pend_r, pend_nxt;
  logic wake_r, wake_nxt, rdy_r, rdy_nxt, win_r, win_nxt;
  logic [15:0] res_r, res_nxt;
  assign enabled = cnv_val[SY_ENABLE][0];
  // Standby stops the converter unless run in standby is set
  assign running = enabled && (!standby_i || runstby_r);
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    pend_nxt = pend_r;
    wake_nxt = 1'b0;
    rdy_nxt = 1'b0;
    win_nxt = 1'b0;
    res_nxt = res_r;
    if (go_start && running) begin
      pend_nxt = 1'b1;
      wake_nxt = onreq_r && sleep_i;
    end
    if (go_flush)
      pend_nxt = 1'b0;
    case (st_r)
      SDC_OFF: begin
        if (running && (!onreq_r || pend_nxt)) begin
          st_nxt = SDC_WARM;
          cnt_nxt = 16'(STARTUP_CYC);
        end
      end
      SDC_WARM: begin
        if (cnt_r > 16'h0001)
          cnt_nxt = cnt_r - 16'h0001;
        else
          st_nxt = SDC_READY;
      end
      SDC_READY: begin
        if (pend_nxt) begin
          st_nxt = SDC_CONV;
          cnt_nxt = 16'(CONV_CYC);
          pend_nxt = 1'b0;
        end else if (onreq_r) begin
          st_nxt = SDC_OFF;
        end
      end
      SDC_CONV: begin
        if (go_flush) begin
          st_nxt = onreq_r ? SDC_OFF : SDC_READY;
        end else if (cnt_r > 16'h0001) begin
          cnt_nxt = cnt_r - 16'h0001;
        end else begin
          res_nxt = sample_i;
          rdy_nxt = ev.resrdy_eo;
          win_nxt = ev.winmon_eo &&
                    (sample_i < cnv_val[SY_WINDOW_LOWER_THRESHOLD] ||
                     sample_i > cnv_val[SY_WINDOW_UPPER_THRESHOLD]);
          st_nxt = onreq_r ? SDC_OFF : SDC_READY;
        end
      end
      default: st_nxt = SDC_OFF;
    endcase
    if (!running && st_r != SDC_OFF) begin
      st_nxt = SDC_OFF;
      pend_nxt = 1'b0;
    end
    if (soft_rst) begin
      st_nxt = SDC_OFF;
      pend_nxt = 1'b0;
      res_nxt = 16'h0000;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= SDC_OFF;
      cnt_r <= 16'h0000;
      pend_r <= 1'b0;
      wake_r <= 1'b0;
      rdy_r <= 1'b0;
      win_r <= 1'b0;
      res_r <= 16'h0000;
    end else if (ce) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      pend_r <= pend_nxt;
      wake_r <= wake_nxt;
      rdy_r <= rdy_nxt;
      win_r <= win_nxt;
      res_r <= res_nxt;
    end
  end
  assign evt_resrdy_o = rdy_r;
  assign evt_winmon_o = win_r;
  assign wake_req_o = wake_r;
  assign analog_on_o = st_r != SDC_OFF;
  assign converting_o = st_r == SDC_CONV;

  // Read mux; synced values read back only after synchronization
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (wb_adr_i == ADR_MAIN) begin
      rd_mux[B_ENABLE] = enabled;
      rd_mux[B_SOFTWARE_RESET_BIT] = busy[SY_SOFTWARE_RESET_BIT];
      rd_mux[B_RUNSTBY] = runstby_r;
      rd_mux[B_ONREQ] = onreq_r;
    end else if (wb_adr_i == ADR_EVT) begin
      rd_mux[5:0] = evt_r;
    end else if (wb_adr_i == ADR_BUSY) begin
      rd_mux[NSYNC-1:0] = busy;
    end else if (wb_adr_i == ADR_STATUS) begin
      rd_mux[3:0] = {running, pend_r, analog_on_o, converting_o};
    end else if (wb_adr_i == ADR_RESULT) begin
      rd_mux[15:0] = res_r;
    end else if (widx != 4'(SY_NONE)) begin
      rd_mux[15:0] = cnv_val[widx];
    end
  end
endmodule

// >>> sdc_pkg.sv
// Purpose: Shared constants and types for the converter control block
// Assumes: Wishbone classic slave, 32-bit data, byte addresses
// Notes: Synchronized registers hold 16 bits, upper bits read zero
package sdc_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam logic [7:0] ADR_MAIN = 8'h00;
  localparam logic [7:0] ADR_EVT = 8'h04;
  localparam logic [7:0] ADR_BUSY = 8'h08;
  localparam logic [7:0] ADR_SYNC0 = 8'h0C;
  localparam logic [7:0] ADR_STATUS = 8'h34;
  localparam logic [7:0] ADR_RESULT = 8'h38;
  // Sync target indexes, also the bit positions in the busy register
  localparam int unsigned NSYNC = 12;
  localparam int unsigned SY_SOFTWARE_RESET_BIT = 0;
  localparam int unsigned SY_ENABLE = 1;
  localparam int unsigned SY_INPUT = 2;
  localparam int unsigned SY_WINDOW_LOWER_THRESHOLD = 5;
  localparam int unsigned SY_WINDOW_UPPER_THRESHOLD = 6;
  localparam int unsigned SY_TRIG = 10;
  localparam int unsigned SY_NONE = 15;
  // Field positions
  localparam int unsigned B_SOFTWARE_RESET_BIT = 0;
  localparam int unsigned B_ENABLE = 1;
  localparam int unsigned B_RUNSTBY = 6;
  localparam int unsigned B_ONREQ = 7;
  localparam int unsigned B_TRIG_FLUSH = 0;
  localparam int unsigned B_TRIG_START = 1;
  localparam logic [15:0] SYNC_RST = 16'h0000;
  localparam logic [5:0] EVT_RST = 6'h00;
  // Analog start-up and conversion timing
  localparam int unsigned STARTUP_NS = 2000;
  localparam int unsigned STARTUP_CYC =
    (STARTUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CONV_CYC = 64;
  typedef struct packed {
    logic winmon_eo;
    logic resrdy_eo;
    logic flush_inv;
    logic start_inv;
    logic flush_ei;
    logic start_ei;
  } sdc_evt_s;
  typedef struct packed {
    logic start;
    logic flush;
  } sdc_evline_s;
  typedef enum logic [1:0] {
    SDC_OFF,
    SDC_WARM,
    SDC_READY,
    SDC_CONV
  } sdc_state_e;
endpackage

// >>> sdc_evsrc.sv
// Purpose: Event channel model feeding the converter event inputs
// Assumes: Bench sets the wanted start and flush levels
// Notes: Levels pass through one register, no resynchronizer
`timescale 1ns/1ns
module sdc_evsrc
  import sdc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] lvl,
  output sdc_evline_s evt_in
);
  sdc_evline_s ev_r, ev_nxt;
  always_comb begin
    ev_nxt = sdc_evline_s'(lvl);
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      ev_r <= '0;
    else
      ev_r <= ev_nxt;
  end
  assign evt_in = ev_r;
endmodule

// >>> sdc_ctrl_chk.sv
// Purpose: Port checker for the converter control block
// Assumes: ce held high by the bench
// Notes: Bound into sdc_ctrl
`timescale 1ns/1ns
module sdc_ctrl_chk
  import sdc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic sleep_i,
  input wire logic evt_resrdy_o,
  input wire logic wake_req_o,
  input wire logic analog_on_o,
  input wire logic converting_o
);
  // Saturates so long runs with the analog side on never wrap
  logic [7:0] on_r, on_nxt;
  always_comb begin
    on_nxt = on_r + 8'h01;
    if (!analog_on_o)
      on_nxt = 8'h00;
    else if (on_r == 8'hFF)
      on_nxt = on_r;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      on_r <= 8'h00;
    else
      on_r <= on_nxt;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_ans;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o;
  endproperty
  a_ans: assert property (p_ans) else $error("bad answer");
  property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("long ack");
  property p_err; wb_err_o |-> $past(wb_we_i) && !wb_ack_o; endproperty
  a_err: assert property (p_err) else $error("bad error");
  property p_con; converting_o |-> analog_on_o; endproperty
  a_con: assert property (p_con) else $error("conv unpowered");
  property p_warm; $rose(converting_o) |-> on_r >= 8'(STARTUP_CYC); endproperty
  a_warm: assert property (p_warm) else $error("short warmup");
  property p_rdy; evt_resrdy_o |-> $past(converting_o); endproperty
  a_rdy: assert property (p_rdy) else $error("stray event");
  property p_evp; evt_resrdy_o |=> !evt_resrdy_o; endproperty
  a_evp: assert property (p_evp) else $error("long event");
  // Wake must power the analog side within a few cycles
  property p_wk; wake_req_o |-> ##[0:4] analog_on_o; endproperty
  a_wk: assert property (p_wk) else $error("bad wake");
  // No wake request unless the system was asleep
  property p_nwk; !$past(sleep_i) |-> !wake_req_o; endproperty
  a_nwk: assert property (p_nwk) else $error("wake awake");
  c_err: cover property (wb_err_o);
  c_end: cover property ($fell(converting_o));
  c_wk: cover property (wake_req_o);
endmodule
bind sdc_ctrl sdc_ctrl_chk u_chk (.mclk(mclk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .sleep_i(sleep_i),
  .evt_resrdy_o(evt_resrdy_o), .wake_req_o(wake_req_o),
  .analog_on_o(analog_on_o), .converting_o(converting_o));

// >>> tb_top.sv
// Purpose: Self-checking bench for sdc_ctrl
// Assumes: ce and sel tied high
// Notes: Array m mirrors register contents
`timescale 1ns/1ns
module tb_top
  import sdc_pkg::*;
;
  logic mclk, rst_n, tick, cyc, stb, we, sl, sby;
  logic ack, err, rr, wm, wk, aon, cv, e;
  logic [7:0] adr;
  logic [15:0] smp;
  logic [1:0] lv;
  logic [31:0] dat, rdat, q;
  logic [31:0] m [16];
  logic [15:0] exp_q [$];
  sdc_evline_s ev;
  int err_count, comparisons, nw, i, bz;
  sdc_ctrl u_dut (.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .gclk_tick(tick),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .evt_in(ev), .sleep_i(sl), .standby_i(sby),
    .sample_i(smp), .evt_resrdy_o(rr), .evt_winmon_o(wm),
    .wake_req_o(wk), .analog_on_o(aon), .converting_o(cv));
  sdc_evsrc u_src (.mclk(mclk), .rst_n(rst_n), .lvl(lv), .evt_in(ev));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk)
    if (wk === 1'b1) nw++;
  task automatic chk(input string s, input logic [31:0] x, y);
    comparisons++;
    if (y !== x) begin
      err_count++;
      $display("mismatch %s exp %h got %h", s, x, y);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do begin
      @(posedge mclk);
      n++;
    end while (!(ack || err) && n < 20);
    if (!(ack || err)) begin
      err_count++;
      print_verdict();
    end
    q = rdat;
    e = err;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic x);
    bus(1'b1, a, d);
    chk("bus error", 32'(x), 32'(e));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, '0);
    chk($sformatf("reg %h", a), x, q);
  endtask
  // Line a settles first so only the a to b step and, with f, the later step to 2'b11 can trigger
  task automatic shot(input logic [5:0] c_e, input logic [1:0] a, b,
    input logic f, input int xc);
    int c, r, w, k;
    logic p, lt;
    c = 0;
    r = 0;
    w = 0;
    p = 1'b0;
    wr(8'h04, 32'(c_e), 1'b0);
    smp <= 16'($urandom);
    lv <= a;
    repeat (3) @(posedge mclk);
    lv <= b;
    for (k = 0; k < 200; k++) begin
      @(posedge mclk);
      if (k == 12 && f) lv <= 2'b11;
      if (cv === 1'b1 && !p) c++;
      p = cv;
      if (rr === 1'b1) r++;
      if (wm === 1'b1) w++;
    end
    lt = smp < m[6][15:0] || smp > m[7][15:0];
    chk("conversions", 32'(xc), 32'(c));
    chk("ready events", 32'(xc != 0 && c_e[4] && !f), 32'(r));
    chk("window events", 32'(xc != 0 && c_e[5] && !f && lt), 32'(w));
    if (xc != 0 && !f) exp_q.push_back(smp);
    if (exp_q.size() > 0) rd(8'h38, {16'h0, exp_q.pop_front()});
    $display("test shot %h done", c_e);
  endtask
  initial begin
    {cyc, stb, we, adr, dat} = '0;
    {rst_n, sl, sby, smp, lv} = '0;
    tick = 1'b1;
    err_count = 0;
    comparisons = 0;
    nw = 0;
    bz = 0;
    i = int'($urandom(32'h815d));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'h04, 0);
    rd(8'h08, 0);
    rd(8'h3C, 0);
    tick <= 1'b0;
    for (i = 0; i < 10; i++) begin
      m[3 + i] = (i == 8) ? 0 : {16'h0, 16'($urandom)};
      wr(8'(12 + 4 * i), m[3 + i], 1'b0);
      bz |= 1 << (i + 2);
      rd(8'h08, 32'(bz));
    end
    wr(8'h18, 32'h1234, 1'b1);
    tick <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(8'h08, 0);
    for (i = 0; i < 10; i++)
      if (i != 8) rd(8'(12 + 4 * i), m[3 + i]);
    tick <= 1'b0;
    wr(8'h00, 2, 1'b0);
    rd(8'h08, 2);
    wr(8'h00, 0, 1'b1);
    tick <= 1'b1;
    repeat (60) @(posedge mclk);
    rd(8'h00, 2);
    $display("test sync done");
    shot(6'h31, 2'b00, 2'b10, 1'b0, 1);
    shot(6'h30, 2'b00, 2'b10, 1'b0, 0);
    shot(6'h05, 2'b10, 2'b00, 1'b0, 1);
    shot(6'h13, 2'b00, 2'b11, 1'b0, 0);
    shot(6'h13, 2'b00, 2'b10, 1'b1, 1);
    chk("early wakes", 0, 32'(nw));
    sl <= 1'b1;
    wr(8'h00, 32'h82, 1'b0);
    shot(6'h11, 2'b00, 2'b10, 1'b0, 1);
    chk("analog after end", 0, 32'(aon));
    chk("wakes", 1, 32'(nw));
    sl <= 1'b0;
    sby <= 1'b1;
    wr(8'h00, 2, 1'b0);
    repeat (6) @(posedge mclk);
    chk("standby analog", 0, 32'(aon));
    wr(8'h00, 32'h42, 1'b0);
    for (i = 0; i < 20 && aon !== 1'b1; i++) @(posedge mclk);
    chk("run in standby", 1, 32'(aon));
    $display("test sleep done");
    // Software trigger start, then start and flush together
    wr(8'h04, 32'h10, 1'b0);
    wr(8'h2C, 2, 1'b0);
    for (i = 0; i < 200 && rr !== 1'b1; i++) @(posedge mclk);
    chk("trigger ready", 1, 32'(rr));
    exp_q.push_back(smp);
    rd(8'h38, {16'h0, exp_q.pop_front()});
    wr(8'h2C, 3, 1'b0);
    rd(8'h34, 32'hA);
    $display("test trigger done");
    wr(8'h00, 1, 1'b0);
    repeat (6) @(posedge mclk);
    rd(8'h04, 0);
    rd(8'h00, 0);
    rd(8'h18, 0);
    $display("test reset bit done");
    print_verdict();
  end
endmodule
